// ---- logic/dhis_top.sv ----
// display host port: parallel bus, serial port, rgb input, tearing output, apb registers
`timescale 1ns/100ps
`include "dhis_cfg.svh"

// Summary of operation
// - chip select high makes every bus and serial access ignored; rgb pixels are still taken
// - serial data sampled on serial clock rise
// - serial read pin driven only when enabled
// - command/data pin tags each received word
// - parallel write strobe low phase writes word
// - write strobe pin is serial clock serially
// - read strobe low drives read data out
// - panel reset low returns logic to start
// - straps 00 sixteen-bit, 01 eight-bit bus
// - straps 11 rgb pixels plus serial commands
// - middle strap fixed high, two straps select
// - pixels taken only while data enable high
// - horizontal sync falling starts a new line
// - vertical sync falling starts a new frame
module dhis_top #(
    parameter int unsigned TE_PERIOD_CYC = `DHIS_TE_PERIOD_CYC
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire dhis_pkg::dhis_pins_t pins_in,
    output logic [15:0] data_bus_out,
    output logic data_bus_oe_out,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    output logic serial_read_out,
    output logic tearing_effect_out
);
    import dhis_pkg::*;

    localparam int unsigned TE_WIDTH_CYC = `DHIS_TE_WIDTH_CYC;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // edge finders on sampled levels
    function automatic logic rose(input logic now, input logic was);
        return now & ~was;
    endfunction

    function automatic logic fell(input logic now, input logic was);
        return ~now & was;
    endfunction

    // word aligned address inside the map
    function automatic logic addr_hit(input logic [11:0] a);
        return (a[1:0] == 2'b00) && (a <= `DHIS_ADDR_FRAME);
    endfunction

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    dhis_pins_t pins_s; // synchronised pins
    dhis_pins_t pins_q; // one cycle older, for edges

    dhis_sync #(
        .WIDTH(30),
        .RST_VAL(`DHIS_PIN_IDLE)
    ) u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .async_in(pins_in),
        .sync_out(pins_s)
    );

    // delay stage for edge detection
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pins_q <= dhis_pins_t'(`DHIS_PIN_IDLE);
        end else begin
            pins_q <= pins_s;
        end
    end

    logic soft_rst; // panel reset pin held low
    assign soft_rst = ~pins_s.panel_reset_n;

    // ----------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------
    dhis_mode_t mode, next_mode; // interface mode, fixed until reset
    logic strap_taken, next_strap_taken; // straps caught since reset

    // straps read once after each reset; mid strap is never looked at
    always_comb begin
        next_mode = mode;
        next_strap_taken = strap_taken;
        if (soft_rst) begin
            next_strap_taken = 1'b0;
        end else if (!strap_taken) begin
            next_mode = dhis_mode_t'({pins_s.mode_strap_high, pins_s.mode_strap_low});
            next_strap_taken = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode <= dhis_mode_par16;
            strap_taken <= 1'b0;
        end else begin
            mode <= next_mode;
            strap_taken <= next_strap_taken;
        end
    end

    logic selected, parallel, is_rgb; // decoded port state
    logic wr_rise, wr_fall; // write strobe / serial clock edges
    assign selected = ~pins_s.chip_select_n & strap_taken;
    assign parallel = (mode == dhis_mode_par16) || (mode == dhis_mode_par8);
    assign is_rgb = (mode == dhis_mode_rgb);
    assign wr_rise = rose(pins_s.write_strobe_n, pins_q.write_strobe_n);
    assign wr_fall = fell(pins_s.write_strobe_n, pins_q.write_strobe_n);

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    logic [2:0] ctrl, next_ctrl; // serial out enable, sda read, te enable
    logic [15:0] read_data, next_read_data; // word returned to the host
    logic [31:0] next_prdata;
    logic wr_en; // write taken at this edge
    logic clr_valid, clr_ovr; // write-one-to-clear strobes
    dhis_word_t rx; // last received word
    logic rx_valid, rx_ovr;
    dhis_pixel_t pixel; // last accepted pixel
    logic [9:0] pix_cnt, line_cnt;
    logic [15:0] frame_cnt;

    assign pready_out = 1'b1; // no wait states, data staged at setup
    assign pslverr_out = psel_in & penable_in & ~addr_hit(paddr_in);
    assign wr_en = psel_in & penable_in & pwrite_in & addr_hit(paddr_in);
    assign clr_valid = wr_en && paddr_in == `DHIS_ADDR_RX_WORD && pwdata_in[`DHIS_RX_VALID_BIT];
    assign clr_ovr = wr_en && paddr_in == `DHIS_ADDR_RX_WORD && pwdata_in[`DHIS_RX_OVERRUN_BIT];

    // control writes taken in the access cycle, read data staged in the setup cycle
    always_comb begin
        next_ctrl = ctrl;
        next_read_data = read_data;
        next_prdata = prdata_out;
        if (wr_en && paddr_in == `DHIS_ADDR_CTRL) begin
            next_ctrl = pwdata_in[2:0];
        end
        if (wr_en && paddr_in == `DHIS_ADDR_READ_DATA) begin
            next_read_data = pwdata_in[15:0];
        end
        if (psel_in && !penable_in && !pwrite_in) begin
            case (paddr_in)
                `DHIS_ADDR_CTRL: next_prdata = {29'h0, ctrl};
                `DHIS_ADDR_READ_DATA: next_prdata = {16'h0, read_data};
                `DHIS_ADDR_RX_WORD: next_prdata = {13'h0, rx_ovr, rx_valid, rx};
                `DHIS_ADDR_STATUS: next_prdata = {27'h0, strap_taken, tearing_effect_out,
                                                  selected, mode};
                `DHIS_ADDR_PIXEL: next_prdata = {14'h0, pixel};
                `DHIS_ADDR_POSITION: next_prdata = {6'h0, line_cnt, 6'h0, pix_cnt};
                `DHIS_ADDR_FRAME: next_prdata = {16'h0, frame_cnt};
                default: next_prdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end
        if (soft_rst) begin
            next_ctrl = `DHIS_CTRL_RST;
            next_read_data = `DHIS_READ_DATA_RST;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl <= `DHIS_CTRL_RST;
            read_data <= `DHIS_READ_DATA_RST;
            prdata_out <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            read_data <= next_read_data;
            prdata_out <= next_prdata;
        end
    end

    // ----------------------------------------------------------------
    // parallel and serial command port
    // ----------------------------------------------------------------
    dhis_word_t next_rx;
    logic next_rx_valid, next_rx_ovr, word_new;
    logic [2:0] bit_cnt, next_bit_cnt; // serial bit position
    logic [6:0] shreg, next_shreg; // first seven serial bits
    logic [15:0] next_data_bus;
    logic next_data_oe, next_sro, next_sda, next_sda_oe, ser_bit;

    assign ser_bit = read_data[3'd7 - bit_cnt]; // msb first

    always_comb begin
        next_rx = rx;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        word_new = 1'b0;
        if (!selected) begin
            next_bit_cnt = 3'd0; // deselect aborts a partial byte
        end else if (parallel && wr_rise) begin
            // data was held through the low phase, sampled at its end
            word_new = 1'b1;
            next_rx.data = (mode == dhis_mode_par8) ? {8'h00, pins_s.data_bus[7:0]}
                                                    : pins_s.data_bus[15:0];
            next_rx.dc = pins_s.data_command_select;
        end else if (is_rgb && wr_rise) begin
            next_shreg = {shreg[5:0], pins_s.serial_data};
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
                word_new = 1'b1;
                next_rx.data = {8'h00, shreg, pins_s.serial_data};
                next_rx.dc = pins_s.data_command_select;
            end
        end
        // hardware set wins over a clear in the same cycle
        next_rx_valid = (rx_valid & ~clr_valid) | word_new;
        next_rx_ovr = (rx_ovr & ~clr_ovr) | (word_new & rx_valid);
        // read strobe low puts the return word on the bus
        next_data_oe = selected & parallel & ~pins_s.read_strobe_n;
        next_data_bus = (mode == dhis_mode_par8) ? {8'h00, read_data[7:0]} : read_data;
        // serial read goes to the separate pin only when enabled
        next_sro = ctrl[`DHIS_CTRL_SOE_BIT] & selected & is_rgb & ser_bit;
        next_sda_oe = ~ctrl[`DHIS_CTRL_SOE_BIT] & ctrl[`DHIS_CTRL_SDA_READ_BIT]
                      & selected & is_rgb;
        next_sda = next_sda_oe & ser_bit;
        if (soft_rst) begin
            next_rx = '0;
            next_bit_cnt = 3'd0;
            next_shreg = 7'h00;
            next_rx_valid = 1'b0;
            next_rx_ovr = 1'b0;
            next_data_oe = 1'b0;
            next_sro = 1'b0;
            next_sda_oe = 1'b0;
            next_sda = 1'b0;
        end
    end

    // outputs move only after a clock edge, never mid-cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx <= '0;
            rx_valid <= 1'b0;
            rx_ovr <= 1'b0;
            bit_cnt <= 3'd0;
            shreg <= 7'h00;
            data_bus_out <= 16'h0000;
            data_bus_oe_out <= 1'b0;
            serial_read_out <= 1'b0;
            serial_data_out <= 1'b0;
            serial_data_oe_out <= 1'b0;
        end else begin
            rx <= next_rx;
            rx_valid <= next_rx_valid;
            rx_ovr <= next_rx_ovr;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            data_bus_out <= next_data_bus;
            data_bus_oe_out <= next_data_oe;
            serial_read_out <= next_sro;
            serial_data_out <= next_sda;
            serial_data_oe_out <= next_sda_oe;
        end
    end

    // ----------------------------------------------------------------
    // rgb pixel input
    // ----------------------------------------------------------------
    dhis_pixel_t next_pixel;
    logic [9:0] next_pix_cnt, next_line_cnt;
    logic [15:0] next_frame_cnt;
    logic hs_last, vs_last, next_hs_last, next_vs_last; // syncs at last dot edge
    logic dot_rise, hs_fall, vs_fall;

    // dot clock must stay well below clk_in/4 for edges to be seen
    assign dot_rise = is_rgb & rose(pins_s.dot_clock, pins_q.dot_clock);
    assign hs_fall = dot_rise & fell(pins_s.hsync_n, hs_last);
    assign vs_fall = dot_rise & fell(pins_s.vsync_n, vs_last);

    always_comb begin
        next_pixel = pixel;
        next_pix_cnt = pix_cnt;
        next_line_cnt = line_cnt;
        next_frame_cnt = frame_cnt;
        next_hs_last = hs_last;
        next_vs_last = vs_last;
        if (dot_rise) begin
            next_hs_last = pins_s.hsync_n;
            next_vs_last = pins_s.vsync_n;
            if (pins_s.data_enable) begin
                next_pixel = dhis_pixel_t'(pins_s.data_bus);
                next_pix_cnt = pix_cnt + 10'd1;
            end
        end
        if (vs_fall) begin
            next_frame_cnt = frame_cnt + 16'd1;
            next_line_cnt = 10'd0;
            next_pix_cnt = 10'd0;
        end else if (hs_fall) begin
            next_line_cnt = line_cnt + 10'd1;
            next_pix_cnt = 10'd0;
        end
        if (soft_rst) begin
            next_pixel = '0;
            next_pix_cnt = 10'd0;
            next_line_cnt = 10'd0;
            next_frame_cnt = 16'd0;
            next_hs_last = 1'b1;
            next_vs_last = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pixel <= '0;
            pix_cnt <= 10'd0;
            line_cnt <= 10'd0;
            frame_cnt <= 16'd0;
            hs_last <= 1'b1;
            vs_last <= 1'b1;
        end else begin
            pixel <= next_pixel;
            pix_cnt <= next_pix_cnt;
            line_cnt <= next_line_cnt;
            frame_cnt <= next_frame_cnt;
            hs_last <= next_hs_last;
            vs_last <= next_vs_last;
        end
    end

    // ----------------------------------------------------------------
    // tearing effect timer
    // ----------------------------------------------------------------
    logic [17:0] te_cnt, next_te_cnt; // position in refresh period
    logic next_te;

    // free running refresh model; host may align writes to its pulse
    always_comb begin
        next_te_cnt = te_cnt + 18'd1;
        if (te_cnt == 18'(TE_PERIOD_CYC - 1)) begin
            next_te_cnt = 18'd0;
        end
        next_te = ctrl[`DHIS_CTRL_TE_EN_BIT] & (te_cnt < 18'(TE_WIDTH_CYC));
        if (soft_rst || !ctrl[`DHIS_CTRL_TE_EN_BIT]) begin
            next_te_cnt = 18'd0;
            next_te = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            te_cnt <= 18'd0;
            tearing_effect_out <= 1'b0;
        end else begin
            te_cnt <= next_te_cnt;
            tearing_effect_out <= next_te;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence par_write_s;
        selected && parallel && wr_rise && !soft_rst;
    endsequence

    sequence line_start_s;
        hs_fall && !vs_fall && !soft_rst;
    endsequence

    chk_ignore_deselect: assert property (pins_s.chip_select_n |-> !word_new)
        else $error("word taken while chip select high");
    chk_serial_shift: assert property (selected && is_rgb && wr_rise && !soft_rst
        |=> shreg[0] == $past(pins_s.serial_data) && bit_cnt == $past(bit_cnt) + 3'd1)
        else $error("serial bit not sampled on clock rise");
    chk_sro_gated: assert property (!ctrl[`DHIS_CTRL_SOE_BIT] |=> !serial_read_out)
        else $error("serial read pin driven while disabled");
    chk_dc_tag: assert property (word_new && !soft_rst
        |=> rx.dc == $past(pins_s.data_command_select))
        else $error("word tagged with wrong command/data flag");
    chk_par_write: assert property (par_write_s |=> rx_valid
        && rx.data[7:0] == $past(pins_s.data_bus[7:0]))
        else $error("parallel write word not stored");
    chk_read_drive: assert property (selected && parallel && !pins_s.read_strobe_n
        && !soft_rst |=> data_bus_oe_out && data_bus_out[7:0] == $past(read_data[7:0]))
        else $error("read strobe low without bus drive");
    chk_soft_reset: assert property (soft_rst |=> !rx_valid && line_cnt == 10'd0
        && !strap_taken && !data_bus_oe_out)
        else $error("panel reset did not clear state");
    chk_strap_mode: assert property (!strap_taken && !soft_rst
        |=> mode == dhis_mode_t'({$past(pins_s.mode_strap_high), $past(pins_s.mode_strap_low)})
        ##1 $stable(mode) || soft_rst)
        else $error("mode does not follow straps");
    chk_pixel_hold: assert property (dot_rise && !pins_s.data_enable && !soft_rst
        |=> $stable(pixel))
        else $error("pixel taken without data enable");
    chk_pixel_map: assert property (dot_rise && pins_s.data_enable && !soft_rst
        |=> pixel.red == $past(pins_s.data_bus[17:12])
        && pixel.blue == $past(pins_s.data_bus[5:0]))
        else $error("pixel colour lanes wrong");
    chk_line_start: assert property (line_start_s |=> pix_cnt == 10'd0
        && line_cnt == $past(line_cnt) + 10'd1)
        else $error("horizontal sync did not start a line");
    chk_frame_start: assert property (vs_fall && !soft_rst |=> line_cnt == 10'd0
        && frame_cnt == $past(frame_cnt) + 16'd1)
        else $error("vertical sync did not start a frame");
    chk_te_pulse: assert property (ctrl[`DHIS_CTRL_TE_EN_BIT] && !soft_rst
        && te_cnt == 18'(TE_WIDTH_CYC) |=> !tearing_effect_out)
        else $error("tearing pulse too long");

endmodule

// ---- logic/dhis_cfg.svh ----
// register map, field positions, reset values and timing counts of the host port
`ifndef DHIS_CFG_SVH
`define DHIS_CFG_SVH

// ----------------------------------------------------------------
// register byte addresses on the apb side
// ----------------------------------------------------------------
`define DHIS_ADDR_CTRL 12'h000
`define DHIS_ADDR_READ_DATA 12'h004
`define DHIS_ADDR_RX_WORD 12'h008
`define DHIS_ADDR_STATUS 12'h00c
`define DHIS_ADDR_PIXEL 12'h010
`define DHIS_ADDR_POSITION 12'h014
`define DHIS_ADDR_FRAME 12'h018

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DHIS_CTRL_SOE_BIT 0
`define DHIS_CTRL_SDA_READ_BIT 1
`define DHIS_CTRL_TE_EN_BIT 2
`define DHIS_CTRL_RST 3'h4
`define DHIS_READ_DATA_RST 16'h0000
`define DHIS_RX_VALID_BIT 17
`define DHIS_RX_OVERRUN_BIT 18

// idle level of every pin bit while the synchroniser is in reset;
// panel reset reads as asserted so straps are caught only once real
`define DHIS_PIN_IDLE 30'h3860_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DHIS_CLK_HZ 10000000
`define DHIS_TE_PERIOD_US 16667
`define DHIS_TE_WIDTH_US 100
`define DHIS_TE_PERIOD_CYC (`DHIS_TE_PERIOD_US * (`DHIS_CLK_HZ / 1000000))
`define DHIS_TE_WIDTH_CYC (`DHIS_TE_WIDTH_US * (`DHIS_CLK_HZ / 1000000))

`endif

// ---- logic/dhis_pkg.sv ----
// types shared by the display host port design
package dhis_pkg;

    // strap coding {high, low}; gray along p16 -> p8 -> rgb
    typedef enum logic [1:0] {
        dhis_mode_par16 = 2'b00,
        dhis_mode_par8 = 2'b01,
        dhis_mode_rgb = 2'b11,
        dhis_mode_bad = 2'b10
    } dhis_mode_t;

    // one received command or data word
    typedef struct packed {
        logic dc;
        logic [15:0] data;
    } dhis_word_t;

    // one rgb pixel as stored, 6 bits per colour
    typedef struct packed {
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } dhis_pixel_t;

    // every input pin of the host port, as one bundle
    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic read_strobe_n;
        logic data_command_select;
        logic serial_data;
        logic dot_clock;
        logic data_enable;
        logic hsync_n;
        logic vsync_n;
        logic panel_reset_n;
        logic mode_strap_low;
        logic mode_strap_high;
        logic [17:0] data_bus;
    } dhis_pins_t;

endpackage

// ---- logic/dhis_sync.sv ----
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/100ps

module dhis_sync #(
    parameter int WIDTH = 30,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta; // first stage, read only by the second

    // ----------------------------------------------------------------
    // two stages, nothing but the second looks at the first
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ---- verification/dhis_host.sv ----
// host controller model that drives the display port pins
`timescale 1ns/100ps
`include "dhis_cfg.svh"

module dhis_host (
    input wire logic clk_in,
    output dhis_pkg::dhis_pins_t pins_out
);
    import dhis_pkg::*;
    // ----------------------------------------
    // idle pins: deselected, panel held in reset
    // ----------------------------------------
    initial pins_out = `DHIS_PIN_IDLE;
    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // straps only count when caught on leaving reset
    task automatic restart(input logic [1:0] mode);
        pins_out.panel_reset_n <= 1'b0;
        {pins_out.mode_strap_high, pins_out.mode_strap_low} <= mode;
        hold(5);
        pins_out.panel_reset_n <= 1'b1;
        hold(6);
    endtask
    // one parallel word, data held over the low phase
    task automatic par_word(input logic cs_n, input logic dc, input logic [15:0] d);
        pins_out.chip_select_n <= cs_n;
        pins_out.data_command_select <= dc;
        pins_out.data_bus <= {2'b00, d};
        hold(4);
        pins_out.write_strobe_n <= 1'b0;
        hold(4);
        pins_out.write_strobe_n <= 1'b1;
        hold(4);
        pins_out.chip_select_n <= 1'b1;
        pins_out.data_bus <= ~{2'b00, d}; // released lines do not keep the word
        hold(1);
    endtask
    // serial byte msb first; clock stands high between frames
    task automatic ser_byte(input logic dc, input logic [7:0] b);
        pins_out.chip_select_n <= 1'b0;
        pins_out.data_command_select <= dc;
        for (int i = 7; i >= 0; i--) begin
            pins_out.serial_data <= b[i];
            pins_out.write_strobe_n <= 1'b0;
            hold(4);
            pins_out.write_strobe_n <= 1'b1;
            hold(4);
        end
        pins_out.chip_select_n <= 1'b1;
        pins_out.serial_data <= ~b[0];
        hold(1);
    endtask
    // select and read strobe together
    task automatic rd(input logic lvl);
        pins_out.chip_select_n <= lvl;
        pins_out.read_strobe_n <= lvl;
        hold(6);
    endtask
    // one dot clock period with sync and enable levels
    task automatic dot(input logic de, input logic hs_n, input logic vs_n, input logic [17:0] px);
        pins_out.data_enable <= de;
        pins_out.hsync_n <= hs_n;
        pins_out.vsync_n <= vs_n;
        pins_out.data_bus <= px;
        hold(4);
        pins_out.dot_clock <= 1'b1;
        hold(4);
        pins_out.dot_clock <= 1'b0;
    endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the display host port
`timescale 1ns/100ps
`include "dhis_cfg.svh"
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end

module testbench;
    import dhis_pkg::*;
    logic clk_in;
    logic nrst_in;
    logic psel_in, penable_in, pwrite_in, last_err;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, d;
    logic pready_out, pslverr_out, data_bus_oe_out, serial_data_out, serial_data_oe_out;
    logic serial_read_out, tearing_effect_out;
    logic [15:0] data_bus_out;
    dhis_pins_t host_pins, pins_in;
    int errors = 0, comparisons = 0, cycles = 0;
    always #50 clk_in = ~clk_in;
    // ----------------------------------------
    // shared wires: the device wins while it drives
    // ----------------------------------------
    always_comb begin
        pins_in = host_pins;
        if (data_bus_oe_out) pins_in.data_bus = {2'b00, data_bus_out};
        if (serial_data_oe_out) pins_in.serial_data = serial_data_out;
    end
    dhis_host i_host (.clk_in(clk_in), .pins_out(host_pins));
    dhis_top #(.TE_PERIOD_CYC(2000)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .pins_in(pins_in), .data_bus_out(data_bus_out),
        .data_bus_oe_out(data_bus_oe_out), .serial_data_out(serial_data_out),
        .serial_data_oe_out(serial_data_oe_out), .serial_read_out(serial_read_out),
        .tearing_effect_out(tearing_effect_out));
    // one apb transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        d = prdata_out;
        last_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        // idle edge, so a following call never re-drives psel in this step
        @(posedge clk_in);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHECK(d, exp)
    endtask
    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        nrst_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        i_host.restart(2'b00);
        rchk(`DHIS_ADDR_CTRL, 32'h4);
        rchk(12'h01c, 32'h0);
        `CHECK(last_err, 1'b1)
        rchk(`DHIS_ADDR_STATUS, 32'h18);
        i_host.par_word(1'b0, 1'b1, 16'ha5c3);
        rchk(`DHIS_ADDR_RX_WORD, 32'h3a5c3);
        apb(1'b1, `DHIS_ADDR_RX_WORD, 32'h60000);
        i_host.par_word(1'b1, 1'b1, 16'h1111);
        rchk(`DHIS_ADDR_RX_WORD, 32'h1a5c3);
        apb(1'b1, `DHIS_ADDR_READ_DATA, 32'h1234);
        i_host.rd(1'b0);
        `CHECK({data_bus_oe_out, data_bus_out}, 17'h11234)
        i_host.rd(1'b1);
        `CHECK(data_bus_oe_out, 1'b0)
        $display("parallel 16 test done");
        i_host.restart(2'b01);
        rchk(`DHIS_ADDR_STATUS, 32'h19);
        i_host.par_word(1'b0, 1'b0, 16'hbeef);
        rchk(`DHIS_ADDR_RX_WORD, 32'h200ef);
        $display("parallel 8 test done");
        i_host.restart(2'b11);
        rchk(`DHIS_ADDR_STATUS, 32'h1b);
        i_host.ser_byte(1'b0, 8'h96);
        rchk(`DHIS_ADDR_RX_WORD, 32'h20096);
        apb(1'b1, `DHIS_ADDR_READ_DATA, 32'h00a5);
        apb(1'b1, `DHIS_ADDR_CTRL, 32'h0);
        i_host.rd(1'b0);
        `CHECK(serial_read_out, 1'b0)
        apb(1'b1, `DHIS_ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk_in);
        `CHECK(serial_read_out, 1'b1)
        apb(1'b1, `DHIS_ADDR_CTRL, 32'h2);
        repeat (3) @(posedge clk_in);
        `CHECK({serial_data_oe_out, serial_data_out, serial_read_out}, 3'b110)
        i_host.rd(1'b1);
        $display("serial test done");
        i_host.dot(1'b1, 1'b1, 1'b1, 18'h3f041);
        i_host.dot(1'b0, 1'b1, 1'b1, 18'h00fff);
        rchk(`DHIS_ADDR_PIXEL, 32'h3f041);
        rchk(`DHIS_ADDR_POSITION, 32'h1);
        i_host.dot(1'b0, 1'b0, 1'b1, 18'h0);
        rchk(`DHIS_ADDR_POSITION, 32'h10000);
        i_host.dot(1'b0, 1'b1, 1'b0, 18'h0);
        rchk(`DHIS_ADDR_FRAME, 32'h1);
        $display("rgb test done");
        apb(1'b1, `DHIS_ADDR_CTRL, 32'h0);
        @(posedge clk_in);
        `CHECK(tearing_effect_out, 1'b0)
        apb(1'b1, `DHIS_ADDR_CTRL, 32'h4);
        repeat (3) @(posedge clk_in);
        `CHECK(tearing_effect_out, 1'b1)
        repeat (1005) @(posedge clk_in);
        `CHECK(tearing_effect_out, 1'b0)
        $display("tearing test done");
        i_host.restart(2'b10);
        rchk(`DHIS_ADDR_STATUS, 32'h1a);
        i_host.par_word(1'b0, 1'b1, 16'h5a5a);
        rchk(`DHIS_ADDR_RX_WORD, 32'h0);
        $display("unsupported mode test done");
        stop_test();
    end
endmodule
